// ==== design/cps_bank.sv ====
// Color processing state bank: APB slave, state store and field decoder
// Contract
// (RULE1) Six 8-bit hue saturation gains, default 220
// (RULE2) Transit slopes are reciprocals of base-hue gaps
// (RULE3) Six 10-bit hue biases, second defaults 150
// (RULE4) Low-chroma threshold 3, width exponent 3
// (RULE5) Skin-tone threshold and slope exponent default zero
// (RULE6) Chroma max reciprocal matches chroma max 448
// (RULE7) Contrast, brightness, hue multipliers applied when enabled
// (RULE8) Brightness/contrast words default 0x00020001, 0x01000000
// (RULE9) Nine coefficients, six offsets, transform enable
// (RULE10) Input and output offsets gated by bits
// (RULE11) Coefficients 0,4 are 1024, 8 is 1204
// (RULE12) Alpha from message or state, bit 16
// (RULE13) Gamut compression enable and mapping mode
// (RULE14) Four mapping lengths and line shift 0-4
// (RULE15) Bit 31 enables extended-gamut decode and encode
// (RULE16) Extended-gamut control effective only under compression
// (RULE17) Force 4:4:4 for 4:4:4 input
// (RULE18) Force 4:2:2 for 4:4:4 input
// (RULE19) Display color space: 0 HD, 1 SD
// (RULE20) Reserved fields written zero, ignored by device
`timescale 1ns/1ns
`default_nettype none
module cps_bank
   import cps_pkg::*;
(
   input  wire logic          core_clk,            // Pixel clock
   input  wire logic          rst,                 // Asynchronous reset, high
   input  wire logic          ce,                  // Clock enable, freezes all registers
   input  wire logic          psel,                // APB select
   input  wire logic          penable,             // APB access phase
   input  wire logic          pwrite,              // APB direction
   input  wire logic [11:0]   paddr,               // APB byte address
   input  wire logic [31:0]   pwdata,              // APB write data
   output logic [31:0]        prdata,              // APB read data
   output logic               pready,              // APB ready
   output logic               pslverr,             // APB error, unmapped
   input  wire logic          input_is_444,        // Pipe: input is 4:4:4
   input  wire logic [15:0]   msg_alpha,           // Pipe: alpha of the message
   output logic [15:0]        alpha_out,           // Alpha chosen for output
   output logic [47:0]        hue_sat_gain,        // Six U1.7 gains
   output logic [59:0]        base_hue,            // Six U10 base hues
   output logic [95:0]        hue_transit_slope,   // Six U0.16 slopes
   output logic [59:0]        hue_bias,            // Six U2.8 biases
   output logic [6:0]         low_chroma_threshold,  // Low-chroma threshold
   output logic [2:0]         low_chroma_width_exp,  // Transition width exponent
   output logic [4:0]         skin_tone_threshold,   // Skin-tone threshold
   output logic [2:0]         skin_tone_slope_exp,   // Skin-tone slope exponent
   output logic [15:0]        chroma_max_reciprocal, // U0.16 of 1/max
   output logic [8:0]         chroma_max_value,      // Max legal |UV|
   output logic [10:0]        bcs_contrast,        // Effective U4.7 gain
   output logic [11:0]        bcs_brightness,      // Effective S7.4 offset
   output logic [15:0]        bcs_cos,             // Effective S7.8 cosine
   output logic [15:0]        bcs_sin,             // Effective S7.8 sine
   output logic [116:0]       matrix_coeff,        // Nine S2.10 coefficients
   output logic               transform_enable,    // Conversion enable
   output logic [29:0]        conv_in_offset,      // Three effective input offsets
   output logic [29:0]        conv_out_offset,     // Three effective output offsets
   output logic               gamut_enable,        // Compression on
   output logic               gamut_advanced,      // Full-range mapping
   output logic [39:0]        gamut_lengths,       // In, out, out-below, in-below
   output logic [2:0]         gamut_line_shift,    // Compression line shift
   output logic               extended_gamut_codec_en, // Effective decode/encode
   output logic               proc_as_444,         // Treat input as 4:4:4
   output logic               proc_as_422,         // Treat input as 4:2:2
   output logic               color_space_sd       // 1 SD, 0 HD
);
   cps_mem_if mem ();   // Bus to the state store

   // Slope against gap: product lies within one gap of 2^16
   function automatic logic slope_ok(input logic [15:0] slope,
                                     input logic [9:0]  gap);
      logic [25:0] prod;
      prod = slope * gap;
      slope_ok = (prod + 26'(gap) >= 26'h10000) && (prod <= 26'h10000 + 26'(gap));
   endfunction : slope_ok

   // Word index decode shared by read and write
   function automatic logic [4:0] slot_of(input logic [7:0] idx);
      slot_of = 5'(idx - CPS_FIRST_IDX);
   endfunction : slot_of

   logic [31:0] w [CPS_NWORDS];   // Current state words
   assign w = mem.words;

   // Bus decode
   wire  [7:0] word_idx = paddr[9:2];                       // Register index
   wire        in_bank  = (word_idx >= CPS_FIRST_IDX) &&
                          (word_idx < CPS_FIRST_IDX + 8'(CPS_NWORDS));
   wire        is_stat  = (word_idx == CPS_STAT_IDX);
   wire        mapped   = (paddr[11:10] == 2'b00) && (in_bank || is_stat);
   wire        setup    = psel && !penable;
   wire        access   = psel && penable;
   wire  [4:0] slot     = slot_of(word_idx);

   // Always ready while enabled: one wait-free access phase
   assign pready  = ce;
   assign pslverr = access && !mapped;

   // Writes only at the completing edge; reserved bits dropped
   assign mem.wr_en   = ce && access && pwrite && in_bank && mapped;
   assign mem.wr_slot = slot;
   // Status and unmapped slots lie past the mask table; keep the index in range
   assign mem.wr_data = pwdata & (in_bank ? CPS_MASK[slot] : 32'h0);   // see RULE20
   assign mem.rd_en   = setup && !pwrite;
   assign mem.rd_slot = in_bank ? slot : 5'h1f;

   cps_regmem #(.DEPTH(CPS_NWORDS)) u_store (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .mem      (mem)
   );

   // Per-hue fields; index 43 holds gains 4..6, gains 1..3 are fixed at 220
   wire [9:0] bc [6];   // Base hue values
   assign bc[0] = w[SL_BASE_A][9:0];
   assign bc[1] = w[SL_BASE_A][19:10];
   assign bc[2] = w[SL_BASE_A][29:20];
   assign bc[3] = w[SL_BASE_B][9:0];
   assign bc[4] = w[SL_BASE_B][19:10];
   assign bc[5] = w[SL_BASE_B][29:20];
   assign base_hue = {bc[5], bc[4], bc[3], bc[2], bc[1], bc[0]};

   // Gains of blue, cyan, green (magenta/red/yellow are fixed at 0xdc)
   assign hue_sat_gain = {w[SL_SAT_B][31:8], 24'hdcdcdc};   // see RULE1
   assign hue_transit_slope = {w[SL_SLOPE_C], w[SL_SLOPE_B], w[SL_SLOPE_A]};
   assign hue_bias = {w[SL_BIAS_B][31:2], w[SL_BIAS_A][31:2]};   // see RULE3

   // Low chroma and skin tone controls
   assign low_chroma_threshold  = w[SL_THRESH][30:24];   // see RULE4
   assign low_chroma_width_exp  = w[SL_THRESH][18:16];   // see RULE4
   assign skin_tone_threshold   = w[SL_THRESH][12:8];    // see RULE5
   assign skin_tone_slope_exp   = w[SL_THRESH][2:0];     // see RULE5
   assign chroma_max_reciprocal = w[SL_UVMAX][31:16];    // see RULE6
   assign chroma_max_value      = w[SL_UVMAX][8:0];      // see RULE6

   // Gap to the next base hue, wrapping sixth back to first
   wire [9:0]  gap [6];   // Adjacent base hue differences
   wire [15:0] slp [6];   // Slopes in gap order 12,23,34,45,56,61
   assign slp[0] = w[SL_SLOPE_A][15:0];
   assign slp[1] = w[SL_SLOPE_A][31:16];
   assign slp[2] = w[SL_SLOPE_B][15:0];
   assign slp[3] = w[SL_SLOPE_B][31:16];
   assign slp[4] = w[SL_SLOPE_C][15:0];
   assign slp[5] = w[SL_SLOPE_C][31:16];
   wire [6:0] slope_good;   // Per-slope and reciprocal consistency
   for (genvar i = 0; i < 6; i++)
   begin : g_gap
      assign gap[i] = bc[(i + 1) % 6] - bc[i];   // see RULE2
      assign slope_good[i] = slope_ok(slp[i], gap[i]);   // see RULE2
   end
   assign slope_good[6] = slope_ok(chroma_max_reciprocal,
                                   {1'b0, chroma_max_value});   // see RULE6

   // Brightness/contrast/hue: neutral values while the stage is off
   wire bcs_on = w[SL_BCS_A][0];   // Stage enable
   assign bcs_contrast   = bcs_on ? w[SL_BCS_A][27:17] : BCS_UNITY_GAIN;  // see RULE7
   assign bcs_brightness = bcs_on ? w[SL_BCS_A][12:1]  : 12'h000;         // see RULE7
   assign bcs_cos        = bcs_on ? w[SL_BCS_B][31:16] : BCS_UNITY_COS;   // see RULE7
   assign bcs_sin        = bcs_on ? w[SL_BCS_B][15:0]  : 16'h0000;        // see RULE7

   // Conversion matrix, coefficient 0 in the low bits
   assign matrix_coeff = {w[SL_CC8][12:0],
                          w[SL_CC67][25:13], w[SL_CC67][12:0],
                          w[SL_CC45][25:13], w[SL_CC45][12:0],
                          w[SL_CC23][25:13], w[SL_CC23][12:0],
                          w[SL_CC01][28:16], w[SL_CC01][15:3]};   // see RULE9
   assign transform_enable = w[SL_CC01][0];                      // see RULE9

   // Offsets: zero when their enable bit is clear
   wire in_ofs_on  = w[SL_CC01][2];   // Input offset enable
   wire out_ofs_on = w[SL_CC01][1];   // Output offset enable
   for (genvar c = 0; c < 3; c++)
   begin : g_ofs
      assign conv_in_offset[c*10 +: 10]  =
         in_ofs_on ? w[SL_OFS1 + c][9:0] : 10'h000;     // see RULE10
      assign conv_out_offset[c*10 +: 10] =
         out_ofs_on ? w[SL_OFS1 + c][19:10] : 10'h000;  // see RULE10
   end

   // Alpha select: message or held state
   wire        alpha_from_state = w[SL_ALPHA][16];
   wire [15:0] alpha_next = alpha_from_state ? w[SL_ALPHA][15:0] : msg_alpha;

   // Alpha register, data output from a flop
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         alpha_out <= 16'h0000;
      else if (ce)
         alpha_out <= alpha_next;   // see RULE12
   end

   // Gamut compression
   assign gamut_enable     = w[SL_GC_A][31];   // see RULE13
   assign gamut_advanced   = w[SL_GC_A][30];   // see RULE13
   assign gamut_lengths    = {w[SL_GC_B][9:0], w[SL_GC_A][9:0],
                              w[SL_GC_A][19:10], w[SL_GC_A][29:20]};   // see RULE14
   // Shift codes above 4 are illegal; clamp rather than pass them on
   assign gamut_line_shift = (w[SL_GC_B][30:28] > 3'd4) ? 3'd4
                                                       : w[SL_GC_B][30:28];  // see RULE14
   assign extended_gamut_codec_en = gamut_enable && w[SL_GC_C][31];   // see RULE15 RULE16
   assign proc_as_444 = input_is_444 && w[SL_GC_C][30];   // see RULE17
   assign proc_as_422 = input_is_444 && w[SL_GC_C][29];   // see RULE18
   // Reserved codes 2..15 fall back to the HD standard
   assign color_space_sd = (w[SL_GC_C][3:0] == CS_SD_CODE);   // see RULE19

   // Status word: live decode state and consistency flags
   wire [31:0] status_word = {16'h0000, 1'b0, slope_good,
                              color_space_sd, proc_as_422, proc_as_444,
                              extended_gamut_codec_en, alpha_from_state,
                              transform_enable, bcs_on, gamut_enable};

   // Status captured at setup so prdata comes from flops
   logic [31:0] stat_reg;   // Captured status
   logic        stat_sel;   // Access targets the status word
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         stat_reg <= 32'h0;
         stat_sel <= 1'b0;
      end
      else if (ce && setup)
      begin
         stat_reg <= status_word;
         stat_sel <= is_stat && mapped;
      end
   end

   // Read data mux of two registers
   assign prdata = stat_sel ? stat_reg : mem.rd_data;

   // Checks
   bcs_gate_a : assert property (@(posedge core_clk) disable iff (rst)   // see RULE7
      !bcs_on |-> (bcs_contrast == BCS_UNITY_GAIN) && (bcs_brightness == 12'h000) &&
                  (bcs_cos == BCS_UNITY_COS) && (bcs_sin == 16'h0000))
      else $error("bcs stage not neutral while off");
   ofs_in_gate_a : assert property (@(posedge core_clk) disable iff (rst)   // see RULE10
      !w[SL_CC01][2] |-> conv_in_offset == 30'h0)
      else $error("input offset leaks while disabled");
   ofs_out_gate_a : assert property (@(posedge core_clk) disable iff (rst)   // see RULE10
      !w[SL_CC01][1] |-> conv_out_offset == 30'h0)
      else $error("output offset leaks while disabled");
   alpha_state_a : assert property (@(posedge core_clk) disable iff (rst)   // see RULE12
      ce && w[SL_ALPHA][16] |=> alpha_out == $past(w[SL_ALPHA][15:0]))
      else $error("alpha not taken from state");
   alpha_msg_a : assert property (@(posedge core_clk) disable iff (rst)   // see RULE12
      ce && !w[SL_ALPHA][16] |=> alpha_out == $past(msg_alpha))
      else $error("alpha not taken from message");
   codec_gate_a : assert property (@(posedge core_clk) disable iff (rst)   // see RULE16
      extended_gamut_codec_en |-> gamut_enable && w[SL_GC_C][31])
      else $error("codec enabled without compression");
   fmt_force_a : assert property (@(posedge core_clk) disable iff (rst)   // see RULE17 RULE18
      !input_is_444 |-> !proc_as_444 && !proc_as_422)
      else $error("format forced on non 4:4:4 input");
   space_sd_a : assert property (@(posedge core_clk) disable iff (rst)   // see RULE19
      color_space_sd |-> w[SL_GC_C][3:0] == 4'h1)
      else $error("sd selected by wrong code");
   write_mask_a : assert property (@(posedge core_clk) disable iff (rst)   // see RULE20
      mem.wr_en && (slot == 5'(SL_THRESH)) |=> w[SL_THRESH] == ($past(pwdata) & 32'h7f071f07))
      else $error("threshold word write wrong");
   reset_bcs_a : assert property (@(posedge core_clk)   // see RULE8
      $fell(rst) |-> w[SL_BCS_A] == 32'h00020001 && w[SL_BCS_B] == 32'h01000000)
      else $error("bcs words reset wrong");
   reset_cc_a : assert property (@(posedge core_clk)   // see RULE11
      $fell(rst) |-> matrix_coeff[12:0] == 13'd1024 && matrix_coeff[116:104] == 13'd1204)
      else $error("matrix reset wrong");
   err_unmapped_a : assert property (@(posedge core_clk) disable iff (rst)   // see RULE20
      access && !mapped |-> pslverr && !mem.wr_en)
      else $error("unmapped access not refused");

endmodule : cps_bank
`default_nettype wire

// ==== design/cps_mem_if.sv ====
// Write and read path between the bank controller and the state store
`timescale 1ns/1ns
`default_nettype none
interface cps_mem_if;
   import cps_pkg::*;
   logic        wr_en;                 // Store one word this cycle
   logic [4:0]  wr_slot;               // Slot written
   logic [31:0] wr_data;               // Masked write data
   logic        rd_en;                 // Capture read data this cycle
   logic [4:0]  rd_slot;               // Slot read
   logic [31:0] rd_data;               // Registered read data
   logic [31:0] words [CPS_NWORDS];    // Whole store, for the field decoder

   modport ctrl (output wr_en, wr_slot, wr_data, rd_en, rd_slot,
                 input rd_data, words);
   modport store (input wr_en, wr_slot, wr_data, rd_en, rd_slot,
                  output rd_data, words);
endinterface : cps_mem_if
`default_nettype wire

// ==== design/cps_pkg.sv ====
// Shared constants for the color processing state register bank
package cps_pkg;

   localparam int unsigned CPS_NWORDS    = 24;            // State words held
   localparam logic [7:0]  CPS_FIRST_IDX = 8'd43;         // Index of first word
   localparam logic [7:0]  CPS_STAT_IDX  = 8'd67;         // Status word index
   localparam int unsigned CPS_AW        = 12;            // APB address width

   // Slot numbers of the words that the decoder reads
   localparam int unsigned SL_SAT_B   = 0;   // Index 43
   localparam int unsigned SL_BASE_A  = 1;   // Index 44
   localparam int unsigned SL_BASE_B  = 2;   // Index 45
   localparam int unsigned SL_SLOPE_A = 3;   // Index 46
   localparam int unsigned SL_SLOPE_B = 4;   // Index 47
   localparam int unsigned SL_SLOPE_C = 5;   // Index 48
   localparam int unsigned SL_BIAS_A  = 6;   // Index 49
   localparam int unsigned SL_BIAS_B  = 7;   // Index 50
   localparam int unsigned SL_THRESH  = 8;   // Index 51
   localparam int unsigned SL_UVMAX   = 9;   // Index 52
   localparam int unsigned SL_BCS_A   = 10;  // Index 53
   localparam int unsigned SL_BCS_B   = 11;  // Index 54
   localparam int unsigned SL_CC01    = 12;  // Index 55
   localparam int unsigned SL_CC23    = 13;  // Index 56
   localparam int unsigned SL_CC45    = 14;  // Index 57
   localparam int unsigned SL_CC67    = 15;  // Index 58
   localparam int unsigned SL_CC8     = 16;  // Index 59
   localparam int unsigned SL_OFS1    = 17;  // Index 60
   localparam int unsigned SL_ALPHA   = 20;  // Index 63
   localparam int unsigned SL_GC_A    = 21;  // Index 64
   localparam int unsigned SL_GC_B    = 22;  // Index 65
   localparam int unsigned SL_GC_C    = 23;  // Index 66

   // Reset value of each state word, slot order
   localparam logic [31:0] CPS_RESET [CPS_NWORDS] = '{   // see RULE8 RULE11 RULE15
      32'hdcdcdc00, 32'h1e34cc91, 32'h3e3cce91, 32'h02e80195,
      32'h0197046b, 32'h01790174, 32'h00096000, 32'h00000000,
      32'h03030000, 32'h009201c0, 32'h00020001, 32'h01000000,
      32'h00002000, 32'h00000000, 32'h00000400, 32'h00000000,
      32'h000004b4, 32'h00000000, 32'h00000000, 32'h00000000,
      32'h00000000, 32'h0cd2911f, 32'h30000334, 32'h8a800000};

   // Writable bits of each word; everything else is stored as zero
   localparam logic [31:0] CPS_MASK [CPS_NWORDS] = '{
      32'hffffff00, 32'h3fffffff, 32'h3fffffff, 32'hffffffff,
      32'hffffffff, 32'hffffffff, 32'hfffffffc, 32'hfffffffc,
      32'h7f071f07, 32'hffff01ff, 32'h0fff1fff, 32'hffffffff,
      32'h1fffffff, 32'h03ffffff, 32'h03ffffff, 32'h03ffffff,
      32'h00001fff, 32'h000fffff, 32'h000fffff, 32'h000fffff,
      32'h0001ffff, 32'hffffffff, 32'h700003ff, 32'hffc0000f};

   // Neutral values the brightness/contrast stage shows when bypassed
   localparam logic [10:0] BCS_UNITY_GAIN = 11'h080;   // 1.0 in U4.7
   localparam logic [15:0] BCS_UNITY_COS  = 16'h0100;  // 1.0 in S7.8
   localparam logic [3:0]  CS_SD_CODE     = 4'h1;      // Standard-definition select

endpackage : cps_pkg

// ==== design/cps_regmem.sv ====
// State word store with reset defaults and a registered read port
`timescale 1ns/1ns
`default_nettype none
module cps_regmem
   import cps_pkg::*;
#(
   parameter int unsigned DEPTH = CPS_NWORDS   // Words held
)(
   input  wire logic core_clk,   // Pixel clock
   input  wire logic rst,        // Asynchronous reset, high
   input  wire logic ce,         // Clock enable
   cps_mem_if.store  mem         // Access port
);
   logic [31:0] word_reg [DEPTH];   // Stored words
   logic [31:0] rd_reg;             // Read data register
   logic        wr_hit;             // Write lands inside the store
   logic        rd_hit;             // Read lands inside the store

   assign wr_hit = mem.wr_en && (32'(mem.wr_slot) < DEPTH);
   assign rd_hit = 32'(mem.rd_slot) < DEPTH;

   // Words: defaults at reset, one write per enabled cycle
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         word_reg <= CPS_RESET;
      else if (ce && wr_hit)
         word_reg[mem.wr_slot] <= mem.wr_data;
   end

   // Read data: out-of-range slots read as zero
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         rd_reg <= 32'h0;
      else if (ce && mem.rd_en)
         rd_reg <= rd_hit ? word_reg[mem.rd_slot] : 32'h0;
   end

   assign mem.rd_data = rd_reg;
   assign mem.words   = word_reg;
endmodule : cps_regmem
`default_nettype wire

// ==== tb/cps_bank_test.sv ====
// Self-checking bench for the color processing state bank
`timescale 1ns/1ns
`default_nettype none
module cps_bank_test;
   import cps_pkg::*;
   logic          core_clk = 1'b0;                  // Pixel clock
   logic          rst = 1'b1;                       // Reset, high
   logic          ce = 1'b1;                        // Clock enable
   logic          psel = 1'b0;                      // APB select
   logic          penable = 1'b0;                   // APB access phase
   logic          pwrite = 1'b0;                    // APB direction
   logic [11:0]   paddr = 12'h000;                  // APB byte address
   logic [31:0]   pwdata = 32'h0, prdata, rd;       // Bus data, last read
   logic          pready, pslverr, er;              // Bus answer, last error
   logic          input_is_444 = 1'b0;              // Pipe format
   logic [15:0]   msg_alpha = 16'h1234, alpha_out;  // Alpha paths
   logic [47:0]   hue_sat_gain;                     // Hue gains
   logic [59:0]   hue_bias, base_hue;               // Hue biases, base hues
   logic [95:0]   hue_transit_slope;                // Transit slopes
   logic [11:0]   bcs_brightness;                   // Effective brightness
   logic          transform_enable;                 // Conversion enable
   logic [6:0]    low_chroma_threshold;             // Low-chroma threshold
   logic [2:0]    low_chroma_width_exp, skin_tone_slope_exp, gamut_line_shift;
   logic [4:0]    skin_tone_threshold;              // Skin-tone threshold
   logic [8:0]    chroma_max_value;                 // Max chroma
   logic [10:0]   bcs_contrast;                     // Effective gain
   logic [15:0]   bcs_cos, bcs_sin, chroma_max_reciprocal;  // Cosine, sine, reciprocal
   logic [116:0]  matrix_coeff;                     // Coefficients
   logic [29:0]   conv_in_offset, conv_out_offset;  // Effective offsets
   logic [39:0]   gamut_lengths;                    // Mapping lengths
   logic          gamut_enable, gamut_advanced, extended_gamut_codec_en;
   logic          proc_as_444, proc_as_422, color_space_sd;
   int            failures = 0, checks_done = 0;    // Verdict counters

   cps_bank dut (.core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .input_is_444(input_is_444), .msg_alpha(msg_alpha),
      .alpha_out(alpha_out), .hue_sat_gain(hue_sat_gain), .base_hue(base_hue),
      .hue_transit_slope(hue_transit_slope),
      .hue_bias(hue_bias), .low_chroma_threshold(low_chroma_threshold),
      .low_chroma_width_exp(low_chroma_width_exp), .skin_tone_threshold(skin_tone_threshold),
      .skin_tone_slope_exp(skin_tone_slope_exp), .chroma_max_reciprocal(chroma_max_reciprocal),
      .chroma_max_value(chroma_max_value), .bcs_contrast(bcs_contrast),
      .bcs_brightness(bcs_brightness), .bcs_cos(bcs_cos), .bcs_sin(bcs_sin),
      .matrix_coeff(matrix_coeff), .transform_enable(transform_enable),
      .conv_in_offset(conv_in_offset), .conv_out_offset(conv_out_offset),
      .gamut_enable(gamut_enable), .gamut_advanced(gamut_advanced),
      .gamut_lengths(gamut_lengths), .gamut_line_shift(gamut_line_shift),
      .extended_gamut_codec_en(extended_gamut_codec_en), .proc_as_444(proc_as_444),
      .proc_as_422(proc_as_422), .color_space_sd(color_space_sd));

   // Free-running pixel clock, 10 ns
   always #5 core_clk = ~core_clk;

   // Verdict and end of run
   task results();
      $display("Checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   // Compare, four-state exact
   task chk(input logic [127:0] got, input logic [127:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; request held until pready is seen high, only the watchdog ends a wait
   task apb(input logic wr_op, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr_op;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Write, then let the decoded outputs settle
   task wr(input logic [7:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd);
      @(posedge core_clk);
      #1;
   endtask : wr

   // Hang guard, far beyond the few hundred cycles needed
   initial
   begin
      repeat (5000) @(posedge core_clk);
      failures++;
      results();
   end

   // Test sequence
   initial
   begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < CPS_NWORDS; i++)
      begin
         apb(1'b0, CPS_FIRST_IDX + 8'(i), 32'h0);
         chk(rd, CPS_RESET[i]);
      end
      chk(hue_sat_gain, 48'hdcdcdcdcdcdc);
      chk(hue_bias, 60'd150 << 10);
      chk(base_hue, {10'd995, 10'd819, 10'd657, 10'd483, 10'd307, 10'd145});
      chk(hue_transit_slope, {16'd377, 16'd372, 16'd407, 16'd1131, 16'd744, 16'd405});
      chk({low_chroma_threshold, low_chroma_width_exp}, {7'd3, 3'd3});
      chk({skin_tone_threshold, skin_tone_slope_exp}, 8'h00);
      chk({chroma_max_reciprocal, chroma_max_value}, {16'd146, 9'd448});
      chk({bcs_contrast, bcs_brightness, bcs_cos, bcs_sin},
          {11'd1, 12'd0, 16'd256, 16'd0});
      chk({matrix_coeff[116:104], matrix_coeff[64:52], matrix_coeff[12:0]},
          {13'd1204, 13'd1024, 13'd1024});
      chk({gamut_lengths, gamut_line_shift}, {10'd820, 10'd287, 10'd164, 10'd205, 3'd3});
      chk({gamut_enable, gamut_advanced, extended_gamut_codec_en, color_space_sd}, 4'h0);
      apb(1'b0, CPS_STAT_IDX, 32'h0);
      chk(rd, 32'h00007102);
      $display("Test defaults done");
      wr(8'd51, 32'hffffffff);
      apb(1'b0, 8'd51, 32'h0);
      chk(rd, 32'h7f071f07);
      apb(1'b1, 8'd70, 32'hffffffff);
      chk(er, 1'b1);
      apb(1'b0, 8'd70, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      $display("Test masking done");
      wr(8'd54, 32'h00c00040);
      wr(8'd53, 32'h0fff1ffe);
      chk({bcs_contrast, bcs_brightness, bcs_cos, bcs_sin},
          {11'h080, 12'h000, 16'h0100, 16'h0000});
      wr(8'd53, 32'h014a0ff1);
      chk({bcs_contrast, bcs_brightness, bcs_cos, bcs_sin},
          {11'h0a5, 12'h7f8, 16'h00c0, 16'h0040});
      wr(8'd60, 32'h000554aa);
      for (int m = 0; m < 4; m++)
      begin
         wr(8'd55, 32'h2000 | {29'h0, m[1:0], m[0]});
         chk({transform_enable, conv_out_offset[9:0], conv_in_offset[9:0]}, {m[0],
             (m[0] ? 10'h155 : 10'h000), (m[1] ? 10'h0aa : 10'h000)});
      end
      wr(8'd63, 32'h0000abcd);
      chk(alpha_out, 16'h1234);
      // Clock enable low: alpha must hold although the message alpha moves
      @(posedge core_clk);
      ce <= 1'b0;
      msg_alpha <= 16'h5678;
      repeat (3) @(posedge core_clk);
      chk({pready, alpha_out}, {1'b0, 16'h1234});
      ce <= 1'b1;
      @(posedge core_clk);
      #1;
      chk(alpha_out, 16'h5678);
      wr(8'd63, 32'h0001abcd);
      chk(alpha_out, 16'habcd);
      $display("Test pipe stages done");
      wr(8'd64, 32'hc0000000);
      chk({gamut_enable, gamut_advanced, extended_gamut_codec_en}, 3'b111);
      wr(8'd66, 32'h00000000);
      chk(extended_gamut_codec_en, 1'b0);
      wr(8'd64, 32'h00000000);
      wr(8'd66, 32'h80000000);
      chk(extended_gamut_codec_en, 1'b0);
      for (int v = 0; v < 8; v += 2)
      begin
         wr(8'd65, {1'b0, v[2:0], 28'h0});
         chk(gamut_line_shift, (v > 4) ? 3'd4 : v[2:0]);
      end
      for (int m = 0; m < 8; m++)
      begin
         @(posedge core_clk);
         input_is_444 <= m[2];
         wr(8'd66, {1'b0, m[1], m[0], 29'h1});
         chk({proc_as_444, proc_as_422, color_space_sd}, {m[2] & m[1], m[2] & m[0], 1'b1});
      end
      wr(8'd66, 32'h00000002);
      chk(color_space_sd, 1'b0);
      $display("Test gamut done");
      results();
   end
endmodule : cps_bank_test
`default_nettype wire
